//--- src/spvcr_pkg.sv
// constants for the switch port vendor configuration register bank
package spvcr_pkg;
    localparam logic [7:0]  SPVCR_OFS_PHY3     = 8'h90;
    localparam logic [7:0]  SPVCR_OFS_PHY4     = 8'h94;
    localparam logic [7:0]  SPVCR_OFS_OPMODE   = 8'h98;
    localparam logic [7:0]  SPVCR_OFS_CAPHDR   = 8'hb0;
    localparam logic [7:0]  SPVCR_OFS_SSID     = 8'hb4;
    localparam logic [7:0]  SPVCR_OFS_GPIO     = 8'hb8;
    localparam logic [6:0]  SPVCR_RST_LANE     = 7'h00;
    localparam logic [16:0] SPVCR_RST_DELTA    = 17'h00001;
    localparam logic [15:0] SPVCR_RST_TXMARGIN = 16'h116b;
    localparam logic [7:0]  SPVCR_RST_RECEIVE_EQUALISATION_UP  = 8'h86;
    localparam logic [7:0]  SPVCR_RST_RECEIVE_EQUALISATION_DN  = 8'h00;
    localparam logic [3:0]  SPVCR_RST_CLKEN    = 4'hf;
    localparam logic [1:0]  SPVCR_STRAP_WAIT   = 2'd2;
    localparam logic [7:0]  SPVCR_CAP_ID       = 8'h0d;
    localparam logic [7:0]  SPVCR_CAP_NEXT     = 8'hc0;
    localparam logic [15:0] SPVCR_RST_SSVID    = 16'h0000;
    localparam logic [15:0] SPVCR_RST_SSID     = 16'h0000;
    localparam int          SPVCR_GPIO_PINS    = 4;
    localparam int          SPVCR_GPIO_IN_POS  = 0;
    localparam int          SPVCR_GPIO_DIR_POS = 1;
    localparam int          SPVCR_GPIO_OUT_POS = 2;
    localparam int          SPVCR_NUM_REFCLK   = 3;
endpackage : spvcr_pkg

//--- src/spvcr_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module spvcr_sync
    import spvcr_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // data
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } spvcr_sync_t;

    spvcr_sync_t s_q;
    spvcr_sync_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.meta = async_i;
        s_d.stab = s_q.meta;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_o = s_q.stab;
endmodule : spvcr_sync

//--- src/spvcr_regs.sv
// vendor configuration register bank of one switch port
// What this block does
// - lane mode bits 6:0 read-only, reset zero
// - delta setting bits 31:15 reset to one
// - tx margin 116b, rx equalisation upstream 86
// - operation mode word packs strap flags
// - powerdown bit from strap, enables reset ones
// - bit 20 one disables all reference clocks
// - bits 18:16 gate each clock pair
// - clock control reloadable by strap, management, eeprom
// - capability id reads 0d
// - next capability pointer reads c0
// - subsystem_vendor_identifier, reloadable, reset zero
// - subsystem device id, reloadable, reset zero
// - gpio register only on upstream port
// - gpio input bit shows pin level
// - gpio direction bit, one means output
// - gpio output value driven when output
`timescale 1ns/1ps
module spvcr_regs
    import spvcr_pkg::*;
#(
    parameter bit UPSTREAM = 1'b1
) (
    // clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst,
    // configuration access
    input  wire logic                        cfg_rd,
    input  wire logic                        cfg_wr,
    input  wire logic [7:0]                  cfg_addr,
    input  wire logic [31:0]                 cfg_wdata,
    input  wire logic [3:0]                  cfg_be,
    output logic      [31:0]                 cfg_rdata,
    output logic                             cfg_rvalid,
    // default loader (management bus or eeprom autoload)
    input  wire logic                        load_clkbuf,
    input  wire logic [4:0]                  load_clkbuf_val,
    input  wire logic                        load_ssvid,
    input  wire logic [15:0]                 load_ssvid_val,
    input  wire logic                        load_ssid,
    input  wire logic [15:0]                 load_ssid_val,
    // straps
    input  wire logic                        clock_buffer_powerdown_strap,
    input  wire logic                        scan_mode_strap,
    input  wire logic [2:0]                  package_select,
    input  wire logic                        physical_layer_mode,
    input  wire logic                        debug_mode_strap,
    input  wire logic                        fast_mode_strap,
    input  wire logic                        quiescent_current_test_n,
    input  wire logic                        serial_rom_skip,
    // reference clock output enables
    output logic      [SPVCR_NUM_REFCLK-1:0] reference_clock_output_pair_en,
    // general purpose pins
    input  wire logic [SPVCR_GPIO_PINS-1:0]  gpio_i,
    output logic      [SPVCR_GPIO_PINS-1:0]  gpio_o,
    output logic      [SPVCR_GPIO_PINS-1:0]  gpio_oe
);
    typedef struct packed {
        logic [1:0]                 strap_wait;
        logic                       powerdown;
        logic [3:0]                 clk_en;
        logic [15:0]                ssvid;
        logic [15:0]                ssid;
        logic [SPVCR_GPIO_PINS-1:0] dir;
        logic [SPVCR_GPIO_PINS-1:0] outv;
        logic [31:0]                rdata;
        logic                       rvalid;
        logic [SPVCR_NUM_REFCLK-1:0] refclk_en;
        logic [SPVCR_GPIO_PINS-1:0] pin_o;
        logic [SPVCR_GPIO_PINS-1:0] pin_oe;
    } spvcr_state_t;

    spvcr_state_t st_q;
    spvcr_state_t st_d;

    // all straps and pins pass two flops before use
    localparam int STRAP_W = 10;
    logic [STRAP_W-1:0]         strap_s;
    logic [SPVCR_GPIO_PINS-1:0] gpio_s;

    spvcr_sync #(.W(STRAP_W)) u_strap_sync (
        .mclk    (mclk),
        .rst     (rst),
        .async_i ({clock_buffer_powerdown_strap, scan_mode_strap, package_select,
                   physical_layer_mode, debug_mode_strap, fast_mode_strap,
                   quiescent_current_test_n, serial_rom_skip}),
        .sync_o  (strap_s)
    );

    spvcr_sync #(.W(SPVCR_GPIO_PINS)) u_gpio_sync (
        .mclk    (mclk),
        .rst     (rst),
        .async_i (gpio_i),
        .sync_o  (gpio_s)
    );

    function automatic logic [31:0] gpio_word(input logic [SPVCR_GPIO_PINS-1:0] pin,
                                              input logic [SPVCR_GPIO_PINS-1:0] dir,
                                              input logic [SPVCR_GPIO_PINS-1:0] outv);
        logic [31:0] w;
        w = '0;
        for (int n = 0; n < SPVCR_GPIO_PINS; n++) begin
            w[4*n+SPVCR_GPIO_IN_POS]  = pin[n];
            w[4*n+SPVCR_GPIO_DIR_POS] = dir[n];
            w[4*n+SPVCR_GPIO_OUT_POS] = outv[n];
        end
        return w;
    endfunction : gpio_word

    logic [7:0]  receive_equalisation;
    logic [31:0] rd_mux;

    always_comb begin
        receive_equalisation   = UPSTREAM ? SPVCR_RST_RECEIVE_EQUALISATION_UP : SPVCR_RST_RECEIVE_EQUALISATION_DN;
        rd_mux = '0;
        case (cfg_addr)
            SPVCR_OFS_PHY3:   rd_mux = {SPVCR_RST_DELTA, 8'h00, SPVCR_RST_LANE};
            SPVCR_OFS_PHY4:   rd_mux = {8'h00, receive_equalisation, SPVCR_RST_TXMARGIN};
            SPVCR_OFS_OPMODE: rd_mux = {11'h000, st_q.powerdown, 1'b0, st_q.clk_en[2:0],
                                        7'h00, strap_s[8:0]};
            SPVCR_OFS_CAPHDR: rd_mux = {16'h0000, SPVCR_CAP_NEXT, SPVCR_CAP_ID};
            SPVCR_OFS_SSID:   rd_mux = {st_q.ssid, st_q.ssvid};
            SPVCR_OFS_GPIO:   rd_mux = UPSTREAM ? gpio_word(gpio_s, st_q.dir, st_q.outv)
                                                : 32'h0000_0000;
            default:          rd_mux = '0;
        endcase
    end

    always_comb begin
        st_d        = st_q;
        st_d.rvalid = cfg_rd;
        st_d.rdata  = cfg_rd ? rd_mux : 32'h0000_0000;
        // the synchroniser restarts from zero, so power-down stays set until the
        // strap level has crossed both flops, then takes it once
        if (st_q.strap_wait != SPVCR_STRAP_WAIT + 2'd1) begin
            st_d.strap_wait = st_q.strap_wait + 2'd1;
        end
        if (st_q.strap_wait == SPVCR_STRAP_WAIT) begin
            st_d.powerdown = strap_s[9];
        end
        if (load_clkbuf) begin
            st_d.powerdown = load_clkbuf_val[4];
            st_d.clk_en    = {1'b1, load_clkbuf_val[2:0]};
        end
        if (load_ssvid) begin
            st_d.ssvid = load_ssvid_val;
        end
        if (load_ssid) begin
            st_d.ssid = load_ssid_val;
        end
        if (UPSTREAM && cfg_wr && cfg_addr == SPVCR_OFS_GPIO) begin
            for (int n = 0; n < SPVCR_GPIO_PINS; n++) begin
                if (cfg_be[n/2]) begin
                    st_d.dir[n]  = cfg_wdata[4*n+SPVCR_GPIO_DIR_POS];
                    st_d.outv[n] = cfg_wdata[4*n+SPVCR_GPIO_OUT_POS];
                end
            end
        end
        // one disables all, zero lets per-pair enables through
        st_d.refclk_en = st_d.powerdown ? '0 : st_d.clk_en[2:0];
        st_d.pin_oe    = UPSTREAM ? st_d.dir : '0;
        st_d.pin_o     = UPSTREAM ? (st_d.outv & st_d.dir) : '0;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q            <= '0;
            st_q.powerdown  <= 1'b1;
            st_q.clk_en     <= SPVCR_RST_CLKEN;
            st_q.ssvid      <= SPVCR_RST_SSVID;
            st_q.ssid       <= SPVCR_RST_SSID;
        end else begin
            st_q <= st_d;
        end
    end

    assign cfg_rdata                      = st_q.rdata;
    assign cfg_rvalid                     = st_q.rvalid;
    assign reference_clock_output_pair_en = st_q.refclk_en;
    assign gpio_o                         = st_q.pin_o;
    assign gpio_oe                        = st_q.pin_oe;
endmodule : spvcr_regs

//--- test/spvcr_regs_props.sv
// assertion checker for the vendor configuration register bank
`timescale 1ns/1ps
module spvcr_regs_props
    import spvcr_pkg::*;
(
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // access and loader
    input wire logic        cfg_rd,
    input wire logic        cfg_wr,
    input wire logic [7:0]  cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic [3:0]  cfg_be,
    input wire logic [31:0] cfg_rdata,
    input wire logic        load_clkbuf,
    input wire logic [4:0]  load_clkbuf_val,
    // pins
    input wire logic [2:0]  reference_clock_output_pair_en,
    input wire logic [3:0]  gpio_o,
    input wire logic [3:0]  gpio_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic       gw;
    logic [3:0] wdir;
    logic [3:0] wout;
    assign gw   = cfg_wr && cfg_addr == 8'hb8 && cfg_be == 4'hf;
    assign wdir = {cfg_wdata[13], cfg_wdata[9], cfg_wdata[5], cfg_wdata[1]};
    assign wout = {cfg_wdata[14], cfg_wdata[10], cfg_wdata[6], cfg_wdata[2]};
    a_lane_delta: assert property (cfg_rd && cfg_addr == 8'h90 |=> cfg_rdata == 32'h00008000)
        else $error("lane and delta readback wrong");
    a_tx_margin: assert property (cfg_rd && cfg_addr == 8'h94 |=> cfg_rdata == 32'h0086116b)
        else $error("margin readback wrong");
    a_cap_header: assert property (cfg_rd && cfg_addr == 8'hb0 |=> cfg_rdata == 32'h0000c00d)
        else $error("capability header wrong");
    a_opmode_rsvd: assert property (cfg_rd && cfg_addr == 8'h98 |=> (cfg_rdata & 32'hffe8fe00) == 0)
        else $error("mode reserved bits set");
    a_clk_gate: assert property (load_clkbuf |=> reference_clock_output_pair_en ==
        ($past(load_clkbuf_val[4]) ? 3'h0 : $past(load_clkbuf_val[2:0])))
        else $error("clock pair enables wrong");
    a_gpio_dir: assert property (gw |=> gpio_oe == $past(wdir))
        else $error("pin direction wrong");
    a_gpio_out: assert property (gw |=> gpio_o == ($past(wout) & $past(wdir)))
        else $error("pin output wrong");
    a_gpio_drive: assert property ((gpio_o & ~gpio_oe) == 4'h0)
        else $error("pin driven while input");
    a_gpio_rsvd: assert property (cfg_rd && cfg_addr == 8'hb8 |=> (cfg_rdata & 32'hffff8888) == 0)
        else $error("pin reserved bits set");
    c_pd: cover property (load_clkbuf && load_clkbuf_val[4]);
    c_gw: cover property (gw);
    c_id: cover property (cfg_rd && cfg_addr == 8'hb4);
endmodule : spvcr_regs_props

//--- test/spvcr_regs_tb_top.sv
// testbench for the vendor configuration register bank
`timescale 1ns/1ps
module spvcr_regs_tb_top;
    logic mclk, rst, cfg_rd, cfg_wr, cfg_rvalid, load_clkbuf, load_ssvid, load_ssid;
    logic [7:0]  cfg_addr;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [3:0]  cfg_be, gpio_i, gpio_o, gpio_oe;
    logic [4:0]  load_clkbuf_val;
    logic [15:0] load_ssvid_val, load_ssid_val;
    logic [2:0]  ref_en;
    logic [8:0]  st;
    logic        pd_strap;
    int          errors, checks_done, cycles;
    spvcr_regs i_spvcr_regs (.mclk(mclk), .rst(rst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .load_clkbuf(load_clkbuf), .load_clkbuf_val(load_clkbuf_val),
        .load_ssvid(load_ssvid), .load_ssvid_val(load_ssvid_val), .load_ssid(load_ssid),
        .load_ssid_val(load_ssid_val), .clock_buffer_powerdown_strap(pd_strap),
        .scan_mode_strap(st[8]), .package_select(st[7:5]), .physical_layer_mode(st[4]),
        .debug_mode_strap(st[3]), .fast_mode_strap(st[2]), .quiescent_current_test_n(st[1]),
        .serial_rom_skip(st[0]), .reference_clock_output_pair_en(ref_en), .gpio_i(gpio_i),
        .gpio_o(gpio_o), .gpio_oe(gpio_oe));
    initial begin
        mclk = 0;
        forever #4 mclk = ~mclk;
    end
    task summarize;
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 1000) begin
            errors++;
            summarize();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge mclk);
        cfg_rd <= !w; cfg_wr <= w; cfg_addr <= a; cfg_wdata <= d; cfg_be <= b;
        @(posedge mclk);
        cfg_rd <= 0; cfg_wr <= 0;
        #1;
    endtask : acc
    task rd(input logic [7:0] a, input logic [31:0] exp);
        acc(0, a, 0, 0);
        chk({31'h0, cfg_rvalid}, 1);
        chk(cfg_rdata, exp);
    endtask : rd
    task ld(input logic [4:0] v);
        @(posedge mclk);
        load_clkbuf <= 1; load_clkbuf_val <= v;
        @(posedge mclk);
        load_clkbuf <= 0;
        #1;
    endtask : ld
    initial begin
        rst = 1; cfg_rd = 0; cfg_wr = 0; cfg_addr = 0; cfg_wdata = 0; cfg_be = 0;
        load_clkbuf = 0; load_ssvid = 0; load_ssid = 0; load_clkbuf_val = 0;
        load_ssvid_val = 0; load_ssid_val = 0; st = 9'h1aa; gpio_i = 4'ha; pd_strap = 1;
        repeat (5) @(posedge mclk);
        rst <= 0;
        @(posedge mclk);
        #1;
        chk({29'h0, ref_en}, 0);
        chk({24'h0, gpio_o, gpio_oe}, 0);
        rd(8'h90, 32'h00008000);
        rd(8'h94, 32'h0086116b);
        rd(8'hb0, 32'h0000c00d);
        rd(8'hb4, 0);
        rd(8'h9c, 0);
        rd(8'h98, 32'h001701aa);
        chk({29'h0, ref_en}, 0);
        st <= 9'h055; pd_strap <= 0; rst <= 1;
        repeat (5) @(posedge mclk);
        rst <= 0;
        repeat (2) @(posedge mclk);
        #1;
        chk({29'h0, ref_en}, 0);
        @(posedge mclk);
        #1;
        chk({29'h0, ref_en}, 7);
        rd(8'h98, 32'h00070055);
        ld(5'h15);
        chk({29'h0, ref_en}, 0);
        rd(8'h98, 32'h00150055);
        ld(5'h0a);
        chk({29'h0, ref_en}, 2);
        rd(8'h98, 32'h00020055);
        @(posedge mclk);
        load_ssvid <= 1; load_ssid <= 1; load_ssvid_val <= 16'h1234; load_ssid_val <= 16'habcd;
        @(posedge mclk);
        load_ssvid <= 0; load_ssid <= 0;
        rd(8'hb4, 32'habcd1234);
        acc(1, 8'hb4, 32'hffffffff, 4'hf);
        rd(8'hb4, 32'habcd1234);
        acc(1, 8'h90, 32'hffffffff, 4'hf);
        rd(8'h90, 32'h00008000);
        acc(1, 8'hb8, 32'hffffffff, 4'hf);
        chk({24'h0, gpio_o, gpio_oe}, 32'hff);
        repeat (3) @(posedge mclk);
        rd(8'hb8, 32'h00007676);
        acc(1, 8'hb8, 32'h00000046, 4'hf);
        chk({24'h0, gpio_o, gpio_oe}, 32'h11);
        gpio_i <= 4'h5;
        repeat (3) @(posedge mclk);
        rd(8'hb8, 32'h00000147);
        acc(1, 8'hb8, 32'h0000ffff, 4'h2);
        chk({24'h0, gpio_o, gpio_oe}, 32'hdd);
        summarize();
    end
endmodule : spvcr_regs_tb_top
bind spvcr_regs spvcr_regs_props i_spvcr_regs_props (.mclk(mclk), .rst(rst), .cfg_rd(cfg_rd),
    .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be),
    .cfg_rdata(cfg_rdata), .load_clkbuf(load_clkbuf), .load_clkbuf_val(load_clkbuf_val),
    .reference_clock_output_pair_en(reference_clock_output_pair_en), .gpio_o(gpio_o),
    .gpio_oe(gpio_oe));
